// ### logic/pin_sync.sv
// two-flop synchroniser for the timer input pins
`timescale 1ns/1ps
module pin_sync (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [timer_hi_pkg::SYNC_W-1:0] async,
	output logic [timer_hi_pkg::SYNC_W-1:0] synced
);
	logic [timer_hi_pkg::SYNC_W-1:0] meta_q;

	// meta_q is read by the second stage only
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= timer_hi_pkg::RESET_SYNC;
			synced <= timer_hi_pkg::RESET_SYNC;
		end else begin
			meta_q <= async;
			synced <= meta_q;
		end
	end
endmodule : pin_sync

// ### logic/timer_half_enable_output_ctrl.sv
// upper timer half: enable modes, output shaping, lower capture edge, apb registers
`timescale 1ns/1ps
module timer_half_enable_output_ctrl (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [timer_hi_pkg::ADDR_W-1:0] paddr,
	input wire logic [timer_hi_pkg::DATA_W-1:0] pwdata,
	output logic [timer_hi_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timerInPinHi,
	input wire logic timerInPinLo,
	output logic timerOutPinHi,
	output logic captureEventLo,
	output logic irq
);
	localparam int DW = timer_hi_pkg::DATA_W;

	////////////////////////////////////////////////////////////////////////////
	// register decode

	function automatic logic isMapped(input logic [timer_hi_pkg::ADDR_W-1:0] a);
		isMapped = (a == timer_hi_pkg::OFS_CONTROL) || (a == timer_hi_pkg::OFS_COUNTER) ||
			(a == timer_hi_pkg::OFS_PERIOD) || (a == timer_hi_pkg::OFS_RELOAD) ||
			(a == timer_hi_pkg::OFS_IRQ_STATUS) || (a == timer_hi_pkg::OFS_IRQ_MASK);
	endfunction : isMapped

	logic [DW-1:0] ctrl_q;
	logic [DW-1:0] cnt_q;
	logic [DW-1:0] cnt_d;
	logic [DW-1:0] prd_q;
	logic [DW-1:0] prd_d;
	logic [DW-1:0] rel_q;
	logic [timer_hi_pkg::IRQ_W-1:0] irqSts_q;
	logic [timer_hi_pkg::IRQ_W-1:0] irqMask_q;
	logic sts_q;
	logic [1:0] pulseLeft_q;
	logic inSync2_q;
	logic loPrev_q;
	logic [timer_hi_pkg::SYNC_W-1:0] pinSynced;
	logic wrEn;
	logic wrCtrl;
	logic wrCnt;
	logic wrPrd;
	logic tick;
	logic extIn;
	logic extPrev_q;
	logic matchD;
	logic wrapD;
	logic capHit;
	timer_hi_pkg::ena_mode_e enaMode;
	timer_hi_pkg::cap_edge_e capEdge;
	logic [1:0] pulseWidth;
	logic clkMode;
	logic inInv;
	logic outInv;
	logic clock_source_select;

	assign enaMode = timer_hi_pkg::ena_mode_e'(ctrl_q[timer_hi_pkg::ENA_MODE_LSB +: 2]);
	assign capEdge = timer_hi_pkg::cap_edge_e'(ctrl_q[timer_hi_pkg::CAP_EDGE_LSB +: 2]);
	assign pulseWidth = ctrl_q[timer_hi_pkg::PULSE_WIDTH_LSB +: 2];
	assign clkMode = ctrl_q[timer_hi_pkg::CLK_PULSE_BIT];
	assign inInv = ctrl_q[timer_hi_pkg::IN_INV_BIT];
	assign outInv = ctrl_q[timer_hi_pkg::OUT_INV_BIT];
	assign clock_source_select = ctrl_q[timer_hi_pkg::CLK_SRC_BIT];

	// apb write lands only at the edge where pready is sampled high
	assign wrEn = psel && penable && pready && pwrite;
	assign wrCtrl = wrEn && (paddr == timer_hi_pkg::OFS_CONTROL);
	assign wrCnt = wrEn && (paddr == timer_hi_pkg::OFS_COUNTER);
	assign wrPrd = wrEn && (paddr == timer_hi_pkg::OFS_PERIOD);

	////////////////////////////////////////////////////////////////////////////
	// apb slave: one wait-free access phase, answer registered in setup

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= timer_hi_pkg::RESET_WORD;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !isMapped(paddr);
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					timer_hi_pkg::OFS_CONTROL: prdata <= ctrl_q |
						(DW'(sts_q) << timer_hi_pkg::STATUS_BIT);
					timer_hi_pkg::OFS_COUNTER: prdata <= cnt_q;
					timer_hi_pkg::OFS_PERIOD: prdata <= prd_q;
					timer_hi_pkg::OFS_RELOAD: prdata <= rel_q;
					timer_hi_pkg::OFS_IRQ_STATUS: prdata <= DW'(irqSts_q);
					timer_hi_pkg::OFS_IRQ_MASK: prdata <= DW'(irqMask_q);
					default: prdata <= timer_hi_pkg::RESET_WORD;
				endcase
			end
		end
	end

	// only the documented fields are stored; the rest read as zero, except bit 16, which reads the output status
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= timer_hi_pkg::RESET_WORD;
		end else if (wrCtrl) begin
			ctrl_q <= '0;
			ctrl_q[timer_hi_pkg::CAP_EDGE_LSB +: 2] <= pwdata[timer_hi_pkg::CAP_EDGE_LSB +: 2];
			ctrl_q[timer_hi_pkg::ENA_MODE_LSB +: 2] <= pwdata[timer_hi_pkg::ENA_MODE_LSB +: 2];
			ctrl_q[timer_hi_pkg::PULSE_WIDTH_LSB +: 2] <=
				pwdata[timer_hi_pkg::PULSE_WIDTH_LSB +: 2];
			ctrl_q[timer_hi_pkg::CLK_SRC_BIT] <= pwdata[timer_hi_pkg::CLK_SRC_BIT];
			ctrl_q[timer_hi_pkg::CLK_PULSE_BIT] <= pwdata[timer_hi_pkg::CLK_PULSE_BIT];
			ctrl_q[timer_hi_pkg::IN_INV_BIT] <= pwdata[timer_hi_pkg::IN_INV_BIT];
			ctrl_q[timer_hi_pkg::OUT_INV_BIT] <= pwdata[timer_hi_pkg::OUT_INV_BIT];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rel_q <= timer_hi_pkg::RESET_WORD;
			irqMask_q <= timer_hi_pkg::RESET_IRQ;
		end else if (wrEn) begin
			if (paddr == timer_hi_pkg::OFS_RELOAD) begin
				rel_q <= pwdata;
			end
			if (paddr == timer_hi_pkg::OFS_IRQ_MASK) begin
				irqMask_q <= pwdata[timer_hi_pkg::IRQ_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// timer clock: internal every cycle, or rising edge of the (inverted) pin

	pin_sync uSync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async({timerInPinLo, timerInPinHi}),
		.synced(pinSynced)
	);

	assign extIn = pinSynced[0] ^ inInv;
	assign tick = clock_source_select ? (extIn && !extPrev_q) : 1'b1;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			extPrev_q <= 1'b0;
			inSync2_q <= 1'b0;
			loPrev_q <= 1'b0;
		end else begin
			extPrev_q <= extIn;
			inSync2_q <= pinSynced[0];
			loPrev_q <= pinSynced[1];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// counter and period

	always_comb begin
		cnt_d = cnt_q;
		prd_d = prd_q;
		matchD = 1'b0;
		wrapD = 1'b0;
		if (tick) begin
			unique case (enaMode)
				timer_hi_pkg::ENA_OFF: cnt_d = cnt_q;
				timer_hi_pkg::ENA_ONCE: begin
					// parked at the period until software rewrites something
					if (cnt_q != prd_q) begin
						cnt_d = cnt_q + 32'h0000_0001;
						matchD = (cnt_d == prd_q);
					end
				end
				timer_hi_pkg::ENA_CONT, timer_hi_pkg::ENA_RELOAD: begin
					if (cnt_q == prd_q) begin
						cnt_d = '0;
						wrapD = 1'b1;
						if (enaMode == timer_hi_pkg::ENA_RELOAD) begin
							prd_d = rel_q;
						end
					end else begin
						cnt_d = cnt_q + 32'h0000_0001;
						matchD = (cnt_d == prd_q);
					end
				end
			endcase
		end
		if (wrCnt) begin
			cnt_d = pwdata;
			matchD = 1'b0;
			wrapD = 1'b0;
		end
		if (wrPrd) begin
			prd_d = pwdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= timer_hi_pkg::RESET_WORD;
			prd_q <= timer_hi_pkg::RESET_WORD;
		end else begin
			cnt_q <= cnt_d;
			prd_q <= prd_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output status: pulse or 50% clock

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sts_q <= 1'b0;
			pulseLeft_q <= 2'h0;
		end else if (clkMode) begin
			pulseLeft_q <= 2'h0;
			if (wrapD) begin
				sts_q <= !sts_q;
			end
		end else if (matchD) begin
			// rising at the match, width reloads on every match
			sts_q <= 1'b1;
			pulseLeft_q <= pulseWidth;
		end else if (sts_q && tick) begin
			if (pulseLeft_q == 2'h0) begin
				sts_q <= 1'b0;
			end else begin
				pulseLeft_q <= pulseLeft_q - 2'h1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			timerOutPinHi <= 1'b0;
		end else begin
			timerOutPinHi <= sts_q ^ outInv;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// lower half capture edge

	always_comb begin
		unique case (capEdge)
			timer_hi_pkg::CAP_RISE: capHit = pinSynced[1] && !loPrev_q;
			timer_hi_pkg::CAP_FALL: capHit = !pinSynced[1] && loPrev_q;
			timer_hi_pkg::CAP_BOTH: capHit = pinSynced[1] != loPrev_q;
			// reserved code: no event rather than a guess
			timer_hi_pkg::CAP_RSVD: capHit = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			captureEventLo <= 1'b0;
		end else begin
			captureEventLo <= capHit;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupts: sticky, write one to clear, set beats clear

	logic [timer_hi_pkg::IRQ_W-1:0] irqSet;
	logic [timer_hi_pkg::IRQ_W-1:0] irqClr;

	assign irqSet = {capHit, matchD};
	assign irqClr = (wrEn && paddr == timer_hi_pkg::OFS_IRQ_STATUS) ?
		pwdata[timer_hi_pkg::IRQ_W-1:0] : '0;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irqSts_q <= timer_hi_pkg::RESET_IRQ;
			irq <= 1'b0;
		end else begin
			irqSts_q <= (irqSts_q & ~irqClr) | irqSet;
			irq <= |(irqSts_q & irqMask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	AST_HOLD_OFF: assert property (
		enaMode == timer_hi_pkg::ENA_OFF && !wrCnt |=> $stable(cnt_q))
		else $error("counter moved while disabled");
	AST_ONCE_PARKED: assert property (
		enaMode == timer_hi_pkg::ENA_ONCE && cnt_q == prd_q && !wrCnt && !wrPrd
		|=> cnt_q == $past(cnt_q))
		else $error("one-shot restarted");
	AST_WRAP_ZERO: assert property (
		tick && enaMode == timer_hi_pkg::ENA_CONT && cnt_q == prd_q && !wrCnt
		|=> cnt_q == '0)
		else $error("no wrap to zero after match");
	AST_RELOAD_PRD: assert property (
		tick && enaMode == timer_hi_pkg::ENA_RELOAD && cnt_q == prd_q && !wrPrd
		|=> prd_q == $past(rel_q))
		else $error("period not reloaded at wrap");
	AST_PULSE_START: assert property (
		!clkMode && matchD |=> sts_q && pulseLeft_q == $past(pulseWidth))
		else $error("pulse did not start at match");
	AST_PULSE_ONE: assert property (
		!clkMode && !clock_source_select && matchD && pulseWidth == 2'h0
		##1 (!matchD && !clkMode) |=> !sts_q)
		else $error("single-cycle pulse too long");
	AST_CLK_TOGGLE: assert property (
		clkMode && wrapD |=> sts_q != $past(sts_q))
		else $error("clock mode did not toggle at zero");
	AST_OUT_POL: assert property (
		##1 timerOutPinHi == ($past(sts_q) ^ $past(outInv)))
		else $error("output pin polarity wrong");
	AST_INT_CLK: assert property (
		!clock_source_select && enaMode != timer_hi_pkg::ENA_OFF && cnt_q < prd_q && !wrCnt |=> $changed(cnt_q))
		else $error("internal clock missed a tick");
	AST_EXT_EDGE: assert property (
		clock_source_select && tick && $stable(inInv) |-> (pinSynced[0] ^ inInv) && !(inSync2_q ^ inInv))
		else $error("external tick without input edge");
	AST_CAP_RISE: assert property (
		capEdge == timer_hi_pkg::CAP_RISE && pinSynced[1] && !loPrev_q |=> captureEventLo)
		else $error("rising capture missed");
	AST_CAP_RSVD: assert property (
		capEdge == timer_hi_pkg::CAP_RSVD |=> !captureEventLo)
		else $error("capture on reserved code");
	AST_IRQ_STICKY: assert property (
		matchD |=> irqSts_q[timer_hi_pkg::IRQ_MATCH_BIT])
		else $error("match event lost");

	COV_WRAP: cover property (enaMode == timer_hi_pkg::ENA_CONT && wrapD);
	COV_RELOAD: cover property (enaMode == timer_hi_pkg::ENA_RELOAD && wrapD);
	COV_PULSE4: cover property (matchD && pulseWidth == 2'h3 && !clkMode);
	COV_CAPTURE: cover property (capEdge == timer_hi_pkg::CAP_BOTH && capHit);
endmodule : timer_half_enable_output_ctrl

// ### pkg/timer_hi_pkg.sv
// constants of the upper timer half control block
package timer_hi_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int SYNC_W = 2;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_COUNTER = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_RELOAD = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;
	localparam int CAP_EDGE_LSB = 12;
	localparam int CLK_SRC_BIT = 24;
	localparam int ENA_MODE_LSB = 22;
	localparam int PULSE_WIDTH_LSB = 20;
	localparam int CLK_PULSE_BIT = 19;
	localparam int IN_INV_BIT = 18;
	localparam int OUT_INV_BIT = 17;
	localparam int STATUS_BIT = 16;
	localparam int IRQ_W = 2;
	localparam int IRQ_MATCH_BIT = 0;
	localparam int IRQ_CAPTURE_BIT = 1;
	localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
	localparam logic [IRQ_W-1:0] RESET_IRQ = 2'h0;
	localparam logic [1:0] RESET_SYNC = 2'h0;
	typedef enum logic [1:0] {
		ENA_OFF,
		ENA_ONCE,
		ENA_CONT,
		ENA_RELOAD
	} ena_mode_e;
	typedef enum logic [1:0] {
		CAP_RISE,
		CAP_FALL,
		CAP_BOTH,
		CAP_RSVD
	} cap_edge_e;
endpackage : timer_hi_pkg

// ### verif/ext_timer_pins.sv
// far-side driver of the two timer input pins
`timescale 1ns/1ps
module ext_timer_pins (
	input wire logic core_clk,
	output logic timerInPinHi,
	output logic timerInPinLo
);
	initial begin
		timerInPinHi = 1'b0;
		timerInPinLo = 1'b0;
	end
	// each level held 4 cycles so the two-flop sync never misses an edge
	task automatic toggle(input bit lo, input int n);
		repeat (n) begin
			repeat (4) @(posedge core_clk);
			if (lo)
				timerInPinLo <= ~timerInPinLo;
			else
				timerInPinHi <= ~timerInPinHi;
		end
		repeat (6) @(posedge core_clk);
	endtask : toggle
endmodule : ext_timer_pins

// ### verif/tb.sv
// self-checking bench of the upper timer half control block
`timescale 1ns/1ps
module tb;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'd90192;
	logic pready, pslverr, timerInPinHi, timerInPinLo, timerOutPinHi, captureEventLo, irq;
	logic err, lvl;
	int num_errors = 0, n_compared = 0, cycles = 0, capCount = 0, hi, per, exp, p;
	always #5 core_clk = ~core_clk;
	timer_half_enable_output_ctrl i_timer_half_enable_output_ctrl (.core_clk, .rst_n, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timerInPinHi,
		.timerInPinLo, .timerOutPinHi, .captureEventLo, .irq);
	ext_timer_pins i_ext_timer_pins (.core_clk, .timerInPinHi, .timerInPinLo);
	////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [31:0] ctl(input int m, w, cp, ii, io, src, cap);
		return 32'(src << 24 | m << 22 | w << 20 | cp << 19 | ii << 18 | io << 17 | cap << 12);
	endfunction : ctl
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	// leading edge wait keeps a release and the next setup in different time steps
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// stop first: a counter above a shrunk period would run for 2^32 ticks
	task automatic setup(input int n);
		apb(1, timer_hi_pkg::OFS_CONTROL, 0);
		apb(1, timer_hi_pkg::OFS_COUNTER, 0);
		apb(1, timer_hi_pkg::OFS_PERIOD, 32'(n));
	endtask : setup
	task automatic measure(input logic pol);
		while ((timerOutPinHi ^ pol) !== 1'b0) @(posedge core_clk);
		while ((timerOutPinHi ^ pol) !== 1'b1) @(posedge core_clk);
		for (hi = 0; (timerOutPinHi ^ pol) === 1'b1; hi++) @(posedge core_clk);
		for (per = hi; (timerOutPinHi ^ pol) === 1'b0; per++) @(posedge core_clk);
	endtask : measure
	////////////////////////////////////////
	always @(posedge core_clk) begin
		cycles++;
		if (captureEventLo === 1'b1)
			capCount++;
		if (cycles == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		check(irq, 0);
		apb(0, timer_hi_pkg::OFS_CONTROL, 0);
		check(rd, 0);
		apb(0, 8'h18, 0);
		check(err, 1);
		check(rd, 0);
		for (int w = 0; w < 4; w++) begin
			seed = lfsr(seed);
			p = 4 + seed % 3;
			setup(p);
			apb(1, timer_hi_pkg::OFS_CONTROL, ctl(2, w, 0, 0, w % 2, 0, 0));
			measure(w[0]);
			check(hi, w + 1);
			check(per, p + 1);
		end
		setup(p);
		apb(1, timer_hi_pkg::OFS_CONTROL, ctl(2, 0, 1, 0, 1, 0, 0));
		measure(1);
		check(per, 2 * p + 2);
		check(hi, p + 1);
		apb(1, timer_hi_pkg::OFS_CONTROL, ctl(0, 0, 1, 0, 1, 0, 0));
		apb(0, timer_hi_pkg::OFS_CONTROL, 0);
		check(rd[16], !timerOutPinHi);
		apb(0, timer_hi_pkg::OFS_COUNTER, 0);
		exp = rd;
		repeat (20) @(posedge core_clk);
		apb(0, timer_hi_pkg::OFS_COUNTER, 0);
		check(rd, exp);
		setup(6);
		apb(1, timer_hi_pkg::OFS_RELOAD, 9);
		apb(1, timer_hi_pkg::OFS_CONTROL, ctl(3, 0, 0, 0, 0, 0, 0));
		repeat (30) @(posedge core_clk);
		apb(0, timer_hi_pkg::OFS_PERIOD, 0);
		check(rd, 9);
		measure(0);
		check(per, 10);
		setup(p);
		apb(1, timer_hi_pkg::OFS_IRQ_STATUS, 3);
		apb(1, timer_hi_pkg::OFS_CONTROL, ctl(1, 0, 0, 0, 0, 0, 0));
		repeat (20) @(posedge core_clk);
		for (int i = 0; i < 2; i++) begin
			apb(0, timer_hi_pkg::OFS_COUNTER, 0);
			check(rd, p);
		end
		apb(0, timer_hi_pkg::OFS_IRQ_STATUS, 0);
		check(rd[0], 1);
		for (int m = 1; m >= 0; m--) begin
			apb(1, timer_hi_pkg::OFS_IRQ_MASK, m);
			repeat (2) @(posedge core_clk);
			check(irq, m);
		end
		apb(1, timer_hi_pkg::OFS_IRQ_STATUS, 1);
		apb(0, timer_hi_pkg::OFS_IRQ_STATUS, 0);
		check(rd[0], 0);
		// odd toggle counts make the inverted and plain pin give different tick counts
		for (int ii = 0; ii < 2; ii++) begin
			setup(100);
			apb(1, timer_hi_pkg::OFS_CONTROL, ctl(0, 0, 0, ii, 0, 1, 0));
			apb(1, timer_hi_pkg::OFS_COUNTER, 0);
			apb(1, timer_hi_pkg::OFS_CONTROL, ctl(2, 0, 0, ii, 0, 1, 0));
			lvl = timerInPinHi;
			exp = 0;
			for (int t = 0; t < 5 - 2 * ii; t++) begin
				lvl = ~lvl;
				exp += (lvl ^ ii[0]);
			end
			i_ext_timer_pins.toggle(0, 5 - 2 * ii);
			apb(0, timer_hi_pkg::OFS_COUNTER, 0);
			check(rd, exp);
		end
		for (int c = 0; c < 4; c++) begin
			apb(1, timer_hi_pkg::OFS_CONTROL, ctl(0, 0, 0, 0, 0, 0, c));
			repeat (4) @(posedge core_clk);
			capCount = 0;
			lvl = timerInPinLo;
			exp = 0;
			for (int t = 0; t < 3; t++) begin
				lvl = ~lvl;
				exp += (c == 2 || (c == 0 && lvl) || (c == 1 && !lvl));
			end
			i_ext_timer_pins.toggle(1, 3);
			check(capCount, exp);
		end
		apb(0, timer_hi_pkg::OFS_IRQ_STATUS, 0);
		check(rd[timer_hi_pkg::IRQ_CAPTURE_BIT], 1);
		tally_and_finish();
	end
endmodule : tb
